// [hdl/rtc_calendar_with_trim.sv]
// Our own choice: the Avalon-MM interface to the registers.
`default_nettype none
// Overview of operation
// R1 - software masks irq before changing interval select
// R2 - hour and alarm hour convert on format change
// R3 - software masks irq around alarm enable change
// R4 - alarm enable held zero while programming alarms
// R5 - hold valid flag readable once hold active
// R6 - sub-counter keeps running; software ends hold quickly
// R7 - hold valid within two rtcc clocks
// R8 - overflow during hold applied after release
// R9 - second write clears sub-counter and pending
// R10 - sub-counter may exceed 8000h under correction
// R11 - seconds bcd 00-59, bad writes ignored
// R12 - minutes bcd 00-59, count on second wrap
// R13 - write wins over same-cycle lower overflow
// R14 - weekday 0-6 counts with day
// R15 - weekday never derived from date
// R16 - month bcd 01-12, bad writes ignored
// R17 - year bcd 00-99, bad writes ignored
// R18 - 12-hour mode bit 5 is pm
// R19 - correction once per minute or thrice
// R20 - software picks thrice mode above 63.1 ppm
// R21 - signed seven-bit correction value decode
// R22 - no correction when magnitude bits 5:1 zero
// R23 - only power-on reset initialises the clock
// R24 - 32768 counts per second plus correction
// R25 - month lengths with leap february
module rtc_calendar_with_trim #(
  parameter int unsigned CLK_HZ  = rtc_pkg::CLK_HZ,
  parameter int unsigned RTCC_HZ = rtc_pkg::RTCC_HZ
) (
  // clock and power-on reset
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  // avalon-mm slave
  input  wire logic [31:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O
);
  localparam logic [24:0] ACC_STEP = 25'(RTCC_HZ);
  localparam logic [24:0] ACC_MOD  = 25'(CLK_HZ);
  localparam int HOLD_WAIT_MAX = 700;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [4:0] bcd2bin(input logic [7:0] v);
    bcd2bin = 5'({4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]});
  endfunction

  function automatic logic [7:0] bin2bcd(input logic [4:0] b);
    bin2bcd = {4'(b / 5'd10), 4'(b % 5'd10)};
  endfunction

  function automatic logic [7:0] hour_to24(input logic [7:0] h);
    logic [4:0] b;
    b = bcd2bin({3'h0, h[4:0]});
    if (b == 5'd12) b = 5'd0;
    if (h[rtc_pkg::PM_BIT]) b = b + 5'd12;
    hour_to24 = bin2bcd(b);
  endfunction

  function automatic logic [7:0] hour_to12(input logic [7:0] h);
    logic [4:0] b;
    logic       pm;
    b  = bcd2bin(h);
    pm = (b >= 5'd12);
    if (pm) b = b - 5'd12;
    if (b == 5'd0) b = 5'd12;
    hour_to12 = bin2bcd(b);
    hour_to12[rtc_pkg::PM_BIT] = pm;
  endfunction

  function automatic logic [7:0] hour_inc(input logic [7:0] h, input logic h24);
    logic [7:0] low;
    logic [7:0] nxt;
    low = {3'h0, h[4:0]};
    nxt = bcd_inc(low);
    if (h24)
      hour_inc = (h == rtc_pkg::H24_MAX) ? rtc_pkg::BCD_ZERO : bcd_inc(h);
    else if (low == rtc_pkg::H12_NOON)
      hour_inc = {2'b00, h[rtc_pkg::PM_BIT], rtc_pkg::BCD_ONE[4:0]};
    else if (low == rtc_pkg::H12_ELVN)
      hour_inc = {2'b00, ~h[rtc_pkg::PM_BIT], rtc_pkg::H12_NOON[4:0]};
    else
      hour_inc = {2'b00, h[rtc_pkg::PM_BIT], nxt[4:0]};
  endfunction

  function automatic logic hour_ok(input logic [7:0] h, input logic h24);
    if (h24)
      hour_ok = bcd_ok(h, rtc_pkg::BCD_ZERO, rtc_pkg::H24_MAX);
    else
      hour_ok = (h[7:6] == 2'b00) &&
                bcd_ok({3'h0, h[4:0]}, rtc_pkg::BCD_ONE, rtc_pkg::H12_NOON);
  endfunction

  function automatic logic [7:0] days_in(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    // 10t+u is divisible by 4 when 2t+u is
    leap = (2'({y[4], 1'b0}) + y[1:0]) == 2'b00;
    if (m == rtc_pkg::FEB)
      days_in = leap ? rtc_pkg::DAY_29 : rtc_pkg::DAY_28;
    else if (m == rtc_pkg::APR || m == rtc_pkg::JUN || m == rtc_pkg::SEP ||
             m == rtc_pkg::NOV)
      days_in = rtc_pkg::DAY_30;
    else
      days_in = rtc_pkg::DAY_MAX;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  rtc_pkg::time_t       tm;
  rtc_pkg::hold_state_t hold_state;
  logic [24:0]          acc;
  logic                 tick;
  logic [15:0]          sub;
  logic                 pending;
  logic                 hold_req;
  logic                 run;
  logic                 alarm_match_enable;
  logic                 alarm_irq_enable;
  logic                 twentyfour_hour_sel;
  logic [2:0]           pis;
  logic                 pflag;
  logic                 aflag;
  logic [7:0]           trim;
  logic [7:0]           almin;
  logic [7:0]           alhour;
  logic [6:0]           alweek;
  logic                 min_tick;
  logic                 hold_valid;
  logic [31:0]          cr_rd;
  logic [31:0]          cr_new;
  logic [31:0]          rd_val;
  logic [7:0]           wd;
  logic                 done;
  logic                 wb0;
  logic                 w_cr;
  logic                 w_sec_ok;
  logic                 twentyfour_hour_sel_flip;
  logic signed [8:0]    corr;
  logic                 trim_slot;
  logic [15:0]          sub_limit;
  logic                 sec_ovf;
  logic                 sec_step;
  logic                 c_sec;
  logic                 c_min;
  logic                 c_hr;
  logic                 c_day;
  logic                 c_mon;
  logic                 p_event;
  logic                 al_event;
  logic                 flag_clr_p;
  logic                 flag_clr_a;

  // bus decode; a write lands at the edge where waitrequest is seen low
  assign done = (AVS_READ_I | AVS_WRITE_I) && !AVS_WAITREQUEST_O;
  assign wd   = AVS_WRITEDATA_I[7:0];
  assign wb0  = done && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
  assign w_cr = done && AVS_WRITE_I && (AVS_ADDRESS_I == rtc_pkg::CR_ADDR);
  assign cr_new = merge(cr_rd, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  assign twentyfour_hour_sel_flip = w_cr && (cr_new[rtc_pkg::TWENTYFOUR_HOUR_SEL_BIT] != twentyfour_hour_sel);
  assign w_sec_ok = wb0 && (AVS_ADDRESS_I == rtc_pkg::SEC_ADDR) &&
                    bcd_ok(wd, rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX); // R11
  assign flag_clr_p = w_cr && AVS_BYTEENABLE_I[rtc_pkg::FLAG_LANE] &&
                      AVS_WRITEDATA_I[rtc_pkg::PFLAG_BIT];
  assign flag_clr_a = w_cr && AVS_BYTEENABLE_I[rtc_pkg::FLAG_LANE] &&
                      AVS_WRITEDATA_I[rtc_pkg::AFLAG_BIT];

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= '0;
    end else if ((AVS_READ_I | AVS_WRITE_I) && AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
      AVS_READDATA_O    <= rd_val;
    end else begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
  end

  always_comb begin
    cr_rd = '0;
    cr_rd[rtc_pkg::HOLD_BIT]       = hold_req;
    cr_rd[rtc_pkg::HOLD_VALID_BIT] = hold_valid; // R5
    cr_rd[rtc_pkg::RUN_BIT]        = run;
    cr_rd[rtc_pkg::ALARM_MATCH_ENABLE_BIT]       = alarm_match_enable;
    cr_rd[rtc_pkg::ALARM_IRQ_ENABLE_BIT]      = alarm_irq_enable;
    cr_rd[rtc_pkg::TWENTYFOUR_HOUR_SEL_BIT]       = twentyfour_hour_sel;
    cr_rd[rtc_pkg::PIS_LSB +: 3]   = pis;
    cr_rd[rtc_pkg::PFLAG_BIT]      = pflag;
    cr_rd[rtc_pkg::AFLAG_BIT]      = aflag;
  end

  always_comb begin
    rd_val = '0;
    case (AVS_ADDRESS_I)
      rtc_pkg::CR_ADDR:     rd_val = cr_rd;
      rtc_pkg::ECR_ADDR:    rd_val[7:0] = trim;
      rtc_pkg::SCNT_ADDR:   rd_val[15:0] = sub;
      rtc_pkg::SEC_ADDR:    rd_val[7:0] = tm.sec;
      rtc_pkg::MIN_ADDR:    rd_val[7:0] = tm.min;
      rtc_pkg::HOUR_ADDR:   rd_val[7:0] = tm.hour;
      rtc_pkg::DAY_ADDR:    rd_val[7:0] = tm.day;
      rtc_pkg::WEEK_ADDR:   rd_val[7:0] = tm.week;
      rtc_pkg::MONTH_ADDR:  rd_val[7:0] = tm.month;
      rtc_pkg::YEAR_ADDR:   rd_val[7:0] = tm.year;
      rtc_pkg::ALMIN_ADDR:  rd_val[7:0] = almin;
      rtc_pkg::ALHOUR_ADDR: rd_val[7:0] = alhour;
      rtc_pkg::ALWEEK_ADDR: rd_val[6:0] = alweek;
      default:              rd_val = '0;
    endcase
  end

  // control; srst is the power-on / wake-up reset, no system reset reaches here
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin // R23
      hold_req <= 1'b0;
      run      <= 1'b0;
      alarm_match_enable     <= 1'b0;
      alarm_irq_enable    <= 1'b0;
      twentyfour_hour_sel     <= 1'b0;
      pis      <= '0;
      trim     <= '0;
    end else begin
      if (w_cr) begin
        hold_req <= cr_new[rtc_pkg::HOLD_BIT];
        run      <= cr_new[rtc_pkg::RUN_BIT];
        alarm_match_enable     <= cr_new[rtc_pkg::ALARM_MATCH_ENABLE_BIT];
        alarm_irq_enable    <= cr_new[rtc_pkg::ALARM_IRQ_ENABLE_BIT];
        twentyfour_hour_sel     <= cr_new[rtc_pkg::TWENTYFOUR_HOUR_SEL_BIT];
        pis      <= cr_new[rtc_pkg::PIS_LSB +: 3];
      end
      if (wb0 && AVS_ADDRESS_I == rtc_pkg::ECR_ADDR) trim <= wd;
    end
  end

  // flags: a same-cycle event beats the write-one clear
  always_comb begin
    unique case (pis)
      rtc_pkg::PI_SEC:  p_event = c_sec;
      rtc_pkg::PI_MIN:  p_event = c_min;
      rtc_pkg::PI_HOUR: p_event = c_hr;
      rtc_pkg::PI_DAY:  p_event = c_day;
      default:          p_event = 1'b0;
    endcase
  end

  assign al_event = min_tick && alarm_match_enable && tm.min == almin && tm.hour == alhour &&
                    alweek[tm.week[2:0]];

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      pflag    <= 1'b0;
      aflag    <= 1'b0;
      min_tick <= 1'b0;
    end else begin
      pflag    <= p_event | (pflag & ~flag_clr_p);
      aflag    <= al_event | (aflag & ~flag_clr_a);
      min_tick <= c_min;
    end
  end

  // rtcc tick: exact fractional divider, jitter of one mclk period
  assign tick = (acc + ACC_STEP) >= ACC_MOD;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) acc <= '0;
    else if (tick) acc <= acc + ACC_STEP - ACC_MOD;
    else acc <= acc + ACC_STEP;
  end

  // hold handshake
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) hold_state <= rtc_pkg::HOLD_IDLE;
    else begin
      unique case (hold_state)
        rtc_pkg::HOLD_IDLE:
          if (hold_req) hold_state <= rtc_pkg::HOLD_WAIT;
        rtc_pkg::HOLD_WAIT:
          if (!hold_req) hold_state <= rtc_pkg::HOLD_IDLE;
          else if (tick) hold_state <= rtc_pkg::HOLD_READY; // R7
        rtc_pkg::HOLD_READY:
          if (!hold_req) hold_state <= rtc_pkg::HOLD_IDLE;
      endcase
    end
  end

  assign hold_valid = (hold_state == rtc_pkg::HOLD_READY);

  // correction decode
  always_comb begin
    if (trim[5:1] == 5'h00) corr = '0; // R22
    else if (!trim[rtc_pkg::TRIM_SIGN_BIT]) corr = $signed({2'b00, trim[5:0] - 6'h1, 1'b0}); // R21
    else corr = -$signed({2'b00, ~trim[5:0] + 6'h1, 1'b0}); // R21
  end

  assign trim_slot = (tm.sec == rtc_pkg::BCD_ZERO) ||
                     (!trim[rtc_pkg::TRIM_INT_BIT] &&
                      (tm.sec == rtc_pkg::SLOT_20 || tm.sec == rtc_pkg::SLOT_40)); // R19
  assign sub_limit = trim_slot ? rtc_pkg::SUB_TOP + 16'(corr) : rtc_pkg::SUB_TOP; // R10
  assign sec_ovf   = run && tick && (sub >= sub_limit); // R24

  // sub-counter runs through a hold; only the carry is deferred
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) sub <= '0;
    else if (w_sec_ok) sub <= '0; // R9
    else if (sec_ovf) sub <= '0;
    else if (run && tick) sub <= sub + 16'h1; // R6
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) pending <= 1'b0;
    else if (w_sec_ok) pending <= 1'b0; // R9
    else if (sec_ovf && hold_req) pending <= 1'b1; // R8
    else if (!hold_req) pending <= 1'b0;
  end

  assign sec_step = !hold_req && (sec_ovf || pending); // R8
  assign c_sec = sec_step && !w_sec_ok;
  assign c_min = c_sec && tm.sec == rtc_pkg::SEC_MAX; // R12
  assign c_hr  = c_min && !(wb0 && AVS_ADDRESS_I == rtc_pkg::MIN_ADDR) &&
                 tm.min == rtc_pkg::SEC_MAX; // R13
  assign c_day = c_hr && !(wb0 && AVS_ADDRESS_I == rtc_pkg::HOUR_ADDR) &&
                 tm.hour == (twentyfour_hour_sel ? rtc_pkg::H24_MAX :
                             {2'b00, 1'b1, rtc_pkg::H12_ELVN[4:0]});
  assign c_mon = c_day && !(wb0 && AVS_ADDRESS_I == rtc_pkg::DAY_ADDR) &&
                 tm.day == days_in(tm.month, tm.year); // R25

  // calendar counters; a valid write always beats the carry
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin // R23
      tm     <= rtc_pkg::TIME_RST;
      almin  <= '0;
      alhour <= rtc_pkg::TIME_RST.hour;
      alweek <= '0;
    end else begin
      if (w_sec_ok) tm.sec <= wd; // R11
      else if (c_sec) tm.sec <= (tm.sec == rtc_pkg::SEC_MAX) ? rtc_pkg::BCD_ZERO : bcd_inc(tm.sec);
      if (wb0 && AVS_ADDRESS_I == rtc_pkg::MIN_ADDR) begin
        if (bcd_ok(wd, rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX)) tm.min <= wd; // R13
      end else if (c_min) begin
        tm.min <= (tm.min == rtc_pkg::SEC_MAX) ? rtc_pkg::BCD_ZERO : bcd_inc(tm.min); // R12
      end
      if (twentyfour_hour_sel_flip) begin
        tm.hour <= twentyfour_hour_sel ? hour_to12(tm.hour) : hour_to24(tm.hour); // R2
        alhour  <= twentyfour_hour_sel ? hour_to12(alhour) : hour_to24(alhour); // R2
      end else begin
        if (wb0 && AVS_ADDRESS_I == rtc_pkg::HOUR_ADDR) begin
          if (hour_ok(wd, twentyfour_hour_sel)) tm.hour <= wd; // R18
        end else if (c_hr) begin
          tm.hour <= hour_inc(tm.hour, twentyfour_hour_sel); // R18
        end
        if (wb0 && AVS_ADDRESS_I == rtc_pkg::ALHOUR_ADDR && hour_ok(wd, twentyfour_hour_sel)) alhour <= wd;
      end
      if (wb0 && AVS_ADDRESS_I == rtc_pkg::DAY_ADDR) begin
        if (bcd_ok(wd, rtc_pkg::BCD_ONE, rtc_pkg::DAY_MAX)) tm.day <= wd;
      end else if (c_day) begin
        tm.day <= c_mon ? rtc_pkg::BCD_ONE : bcd_inc(tm.day); // R25
      end
      // weekday moves only by its own count or a write
      if (wb0 && AVS_ADDRESS_I == rtc_pkg::WEEK_ADDR) begin
        if (bcd_ok(wd, rtc_pkg::BCD_ZERO, rtc_pkg::WEEK_MAX)) tm.week <= wd; // R14
      end else if (c_day) begin
        tm.week <= (tm.week == rtc_pkg::WEEK_MAX) ? rtc_pkg::BCD_ZERO : tm.week + 8'h01; // R15
      end
      if (wb0 && AVS_ADDRESS_I == rtc_pkg::MONTH_ADDR) begin
        if (bcd_ok(wd, rtc_pkg::BCD_ONE, rtc_pkg::MONTH_MAX)) tm.month <= wd; // R16
      end else if (c_mon) begin
        tm.month <= (tm.month == rtc_pkg::MONTH_MAX) ? rtc_pkg::BCD_ONE : bcd_inc(tm.month);
      end
      if (wb0 && AVS_ADDRESS_I == rtc_pkg::YEAR_ADDR) begin
        if (bcd_ok(wd, rtc_pkg::BCD_ZERO, rtc_pkg::YEAR_MAX)) tm.year <= wd; // R17
      end else if (c_mon && tm.month == rtc_pkg::MONTH_MAX) begin
        tm.year <= (tm.year == rtc_pkg::YEAR_MAX) ? rtc_pkg::BCD_ZERO : bcd_inc(tm.year); // R13
      end
      if (wb0 && AVS_ADDRESS_I == rtc_pkg::ALMIN_ADDR &&
          bcd_ok(wd, rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX)) almin <= wd;
      if (wb0 && AVS_ADDRESS_I == rtc_pkg::ALWEEK_ADDR) alweek <= wd[6:0];
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  property p_hold_ready;
    $rose(hold_req) |-> ##[1:HOLD_WAIT_MAX] (hold_valid || !hold_req);
  endproperty
  a_hold_ready: assert property (p_hold_ready) else $error("hold not granted in time"); // R7

  property p_sec_clear;
    w_sec_ok |=> (sub == 16'h0000) && !pending;
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("second write left sub-counter"); // R9

  property p_release;
    (!hold_req && pending && !w_sec_ok) |=> (tm.sec != $past(tm.sec)) && !pending;
  endproperty
  a_release: assert property (p_release) else $error("held second lost"); // R8

  property p_sec_range;
    bcd_ok(tm.sec, rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX);
  endproperty
  a_sec_range: assert property (p_sec_range) else $error("seconds out of range"); // R11

  property p_min_carry;
    (c_min && !(wb0 && AVS_ADDRESS_I == rtc_pkg::MIN_ADDR) && tm.min != rtc_pkg::SEC_MAX)
      |=> tm.min == bcd_inc($past(tm.min));
  endproperty
  a_min_carry: assert property (p_min_carry) else $error("minute did not count"); // R12

  property p_write_wins;
    (c_min && wb0 && AVS_ADDRESS_I == rtc_pkg::MIN_ADDR &&
     bcd_ok(wd, rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX)) |=> tm.min == $past(wd);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("carry beat minute write"); // R13

  property p_week;
    (tm.week <= rtc_pkg::WEEK_MAX) and
    ((c_day && !(wb0 && AVS_ADDRESS_I == rtc_pkg::WEEK_ADDR)) |=> $changed(tm.week));
  endproperty
  a_week: assert property (p_week) else $error("weekday wrong"); // R14

  property p_month_year;
    bcd_ok(tm.month, rtc_pkg::BCD_ONE, rtc_pkg::MONTH_MAX) &&
    bcd_ok(tm.year, rtc_pkg::BCD_ZERO, rtc_pkg::YEAR_MAX);
  endproperty
  a_month_year: assert property (p_month_year) else $error("month or year out of range"); // R16

  property p_trim_off;
    (trim[5:1] == 5'h00) |-> (corr == 9'sd0) && (sub_limit == rtc_pkg::SUB_TOP);
  endproperty
  a_trim_off: assert property (p_trim_off) else $error("correction while disabled"); // R22

  property p_to24;
    (twentyfour_hour_sel_flip && !twentyfour_hour_sel) |=> twentyfour_hour_sel && tm.hour == hour_to24($past(tm.hour));
  endproperty
  a_to24: assert property (p_to24) else $error("hour not converted"); // R2

  property p_pm;
    !twentyfour_hour_sel |-> hour_ok(tm.hour, 1'b0);
  endproperty
  a_pm: assert property (p_pm) else $error("bad 12-hour value"); // R18

  c_hold: cover property ($rose(hold_valid));
  c_big_sub: cover property (sub > rtc_pkg::SUB_TOP);
  c_alarm: cover property ($rose(aflag));
  c_flip: cover property (twentyfour_hour_sel_flip);
endmodule
`default_nettype wire

// [hdl/rtc_pkg.sv]
`default_nettype none
package rtc_pkg;
  localparam int unsigned CLK_HZ  = 20_000_000;
  localparam int unsigned RTCC_HZ = 32_768;

  localparam logic [31:0] CR_ADDR     = 32'h4000_5200;
  localparam logic [31:0] ECR_ADDR    = 32'h4000_5204;
  localparam logic [31:0] SCNT_ADDR   = 32'h4000_5208;
  localparam logic [31:0] SEC_ADDR    = 32'h4000_520C;
  localparam logic [31:0] MIN_ADDR    = 32'h4000_5210;
  localparam logic [31:0] HOUR_ADDR   = 32'h4000_5214;
  localparam logic [31:0] DAY_ADDR    = 32'h4000_5218;
  localparam logic [31:0] WEEK_ADDR   = 32'h4000_521C;
  localparam logic [31:0] MONTH_ADDR  = 32'h4000_5220;
  localparam logic [31:0] YEAR_ADDR   = 32'h4000_5224;
  localparam logic [31:0] ALMIN_ADDR  = 32'h4000_5228;
  localparam logic [31:0] ALHOUR_ADDR = 32'h4000_522C;
  localparam logic [31:0] ALWEEK_ADDR = 32'h4000_5230;

  localparam int HOLD_BIT       = 0;
  localparam int HOLD_VALID_BIT = 1;
  localparam int RUN_BIT        = 4;
  localparam int ALARM_MATCH_ENABLE_BIT       = 8;
  localparam int ALARM_IRQ_ENABLE_BIT      = 9;
  localparam int TWENTYFOUR_HOUR_SEL_BIT       = 10;
  localparam int PIS_LSB        = 12;
  localparam int PFLAG_BIT      = 16;
  localparam int AFLAG_BIT      = 17;
  localparam int FLAG_LANE      = 2;
  localparam int TRIM_SIGN_BIT  = 6;
  localparam int TRIM_INT_BIT   = 7;
  localparam int PM_BIT         = 5;

  localparam logic [2:0] PI_SEC  = 3'h1;
  localparam logic [2:0] PI_MIN  = 3'h2;
  localparam logic [2:0] PI_HOUR = 3'h3;
  localparam logic [2:0] PI_DAY  = 3'h4;

  localparam logic [15:0] SUB_TOP   = 16'h7FFF;
  localparam logic [7:0]  BCD_ZERO  = 8'h00;
  localparam logic [7:0]  BCD_ONE   = 8'h01;
  localparam logic [7:0]  SEC_MAX   = 8'h59;
  localparam logic [7:0]  SLOT_20   = 8'h20;
  localparam logic [7:0]  SLOT_40   = 8'h40;
  localparam logic [7:0]  H24_MAX   = 8'h23;
  localparam logic [7:0]  H12_NOON  = 8'h12;
  localparam logic [7:0]  H12_ELVN  = 8'h11;
  localparam logic [7:0]  WEEK_MAX  = 8'h06;
  localparam logic [7:0]  MONTH_MAX = 8'h12;
  localparam logic [7:0]  YEAR_MAX  = 8'h99;
  localparam logic [7:0]  DAY_MAX   = 8'h31;
  localparam logic [7:0]  DAY_30    = 8'h30;
  localparam logic [7:0]  DAY_29    = 8'h29;
  localparam logic [7:0]  DAY_28    = 8'h28;
  localparam logic [7:0]  FEB       = 8'h02;
  localparam logic [7:0]  APR       = 8'h04;
  localparam logic [7:0]  JUN       = 8'h06;
  localparam logic [7:0]  SEP       = 8'h09;
  localparam logic [7:0]  NOV       = 8'h11;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] week;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } time_t;

  localparam time_t TIME_RST = '{year: 8'h00, month: 8'h01, week: 8'h00, day: 8'h01,
                                 hour: 8'h12, min: 8'h00, sec: 8'h00};

  typedef enum logic [1:0] {HOLD_IDLE, HOLD_WAIT, HOLD_READY} hold_state_t;
endpackage
`default_nettype wire

// [tb/rtc_calendar_with_trim_tb.sv]
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module rtc_calendar_with_trim_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RTCC = rtc_pkg::RTCC_HZ;
  logic        mclk;
  logic        srst;
  logic [31:0] addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_req;
  logic [31:0] q;
  logic [15:0] sub0;
  int          err_total;
  int          n_tests;
  int          k;
  // counter address, value in range, value out of range
  logic [31:0] ta [5] = '{rtc_pkg::SEC_ADDR, rtc_pkg::MIN_ADDR, rtc_pkg::WEEK_ADDR,
                          rtc_pkg::MONTH_ADDR, rtc_pkg::YEAR_ADDR};
  logic [7:0]  tg [5] = '{8'h59, 8'h59, 8'h06, 8'h12, 8'h99};
  logic [7:0]  tb [5] = '{8'h60, 8'h5A, 8'h07, 8'h13, 8'hA0};

  // short rtcc divide keeps hold latency within a few cycles
  rtc_calendar_with_trim #(.CLK_HZ(4 * RTCC), .RTCC_HZ(RTCC)) u_rtc_calendar_with_trim (
    .MCLK_I           (mclk),
    .SRST_I           (srst),
    .AVS_ADDRESS_I    (addr),
    .AVS_READ_I       (rd),
    .AVS_WRITE_I      (wr),
    .AVS_WRITEDATA_I  (wdata),
    .AVS_BYTEENABLE_I (be),
    .AVS_READDATA_O   (rdata),
    .AVS_WAITREQUEST_O(wait_req)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic results();
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one avalon transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr  <= a;
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    @(posedge mclk);
    while (wait_req !== 1'b0) begin
      n++;
      if (n > 50) begin
        err_total++;
        results();
      end
      @(posedge mclk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // extra edge so no strobe is driven twice in one step
    @(posedge mclk);
  endtask

  initial begin
    srst = 1'b1; addr = 32'h0; rd = 1'b0; wr = 1'b0; wdata = 32'h0; be = 4'hF;
    err_total = 0;
    n_tests = 0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    bus(1'b0, rtc_pkg::SEC_ADDR, 32'h0);
    `CHK("sec_rst", 8'h00, q[7:0])
    bus(1'b0, rtc_pkg::HOUR_ADDR, 32'h0);
    `CHK("hour_rst_am", 8'h12, q[7:0])
    bus(1'b0, rtc_pkg::CR_ADDR, 32'h0);
    `CHK("cr_rst", 32'h0000_0000, q)
    for (k = 0; k < 5; k++) begin
      bus(1'b1, ta[k], {24'h0, tg[k]});
      bus(1'b0, ta[k], 32'h0);
      `CHK("cnt_good", tg[k], q[7:0])
      bus(1'b1, ta[k], {24'h0, tb[k]});
      bus(1'b0, ta[k], 32'h0);
      `CHK("cnt_bad", tg[k], q[7:0])
    end
    bus(1'b1, rtc_pkg::MONTH_ADDR, 32'h0);
    bus(1'b0, rtc_pkg::MONTH_ADDR, 32'h0);
    `CHK("month_zero", 8'h12, q[7:0])
    bus(1'b1, rtc_pkg::ALHOUR_ADDR, 32'h0000_0012);
    bus(1'b1, rtc_pkg::CR_ADDR, 32'h0000_0011);
    k = 0;
    q = 32'h0;
    while (q[1] !== 1'b1 && k < 10) begin
      bus(1'b0, rtc_pkg::CR_ADDR, 32'h0);
      k++;
    end
    `CHK("hold_valid", 1'b1, q[1])
    bus(1'b1, rtc_pkg::SEC_ADDR, 32'h0000_0030);
    bus(1'b0, rtc_pkg::SCNT_ADDR, 32'h0);
    sub0 = q[15:0];
    `CHK("sub_cleared", 1'b1, sub0 < 16'h0004)
    repeat (40) @(posedge mclk);
    bus(1'b0, rtc_pkg::SCNT_ADDR, 32'h0);
    `CHK("sub_runs_in_hold", 1'b1, q[15:0] > sub0)
    bus(1'b1, rtc_pkg::CR_ADDR, 32'h0000_0411);
    bus(1'b0, rtc_pkg::HOUR_ADDR, 32'h0);
    `CHK("hour_24h", 8'h00, q[7:0])
    bus(1'b0, rtc_pkg::ALHOUR_ADDR, 32'h0);
    `CHK("alhour_24h", 8'h00, q[7:0])
    bus(1'b1, rtc_pkg::ECR_ADDR, 32'h0000_002C);
    bus(1'b0, rtc_pkg::ECR_ADDR, 32'h0);
    `CHK("trim_rb", 8'h2C, q[7:0])
    // interval change, then flag clear, as masked software would do
    bus(1'b1, rtc_pkg::CR_ADDR, 32'h0000_1411);
    bus(1'b1, rtc_pkg::CR_ADDR, 32'h0001_1411);
    bus(1'b0, rtc_pkg::CR_ADDR, 32'h0);
    `CHK("pis_set", 32'h0000_1413, q)
    bus(1'b1, rtc_pkg::CR_ADDR, 32'h0002_1511);
    bus(1'b0, rtc_pkg::CR_ADDR, 32'h0);
    `CHK("alarm_match_enable_set", 32'h0000_1513, q)
    bus(1'b0, 32'h4000_5234, 32'h0);
    `CHK("unmapped", 32'h0000_0000, q)
    results();
  end
endmodule
`default_nettype wire
